// *** logic/mcaf_top.v ***
// Command control flow: configure, read, initiate and fetch
`timescale 1ns/1ps
`include "mcaf_defines.vh"

// Summary of operation
// - Configure loads presets, never starts measuring
// - Bare AC keyword means volts ac
// - Range: number in limits, MIN, MAX, DEF
// - Resolution in units; DEF is 5.5 digits
// - AC functions fixed at 6.5 digits
// - Frequency single range, zero without signal
// - Period single range, zero without signal
// - Temperature range field selects sensor curve
// - Diode fixed range, current and voltage options
// - Continuity fixed 1 kohm, 5.5 digits
// - Ratio mode, range on input terminals only
// - Configure sets the preset conditions
// - READ measures on next trigger into buffer
// - Full output buffer suspends measuring
// - INIT stores readings in 5000-entry memory
// - INIT refuses commands except bus trigger and device clear
// - FETCH copies memory into output buffer
// - Numeric amplitude picks fitting range
module mcaf_top (
  input  wire        i_clock,
  input  wire        i_rstn,
  // Parsed command
  input  wire        i_cmd_valid,
  output wire        o_cmd_ready,
  input  wire [2:0]  i_cmd_op,
  input  wire [3:0]  i_cmd_func,
  input  wire        i_cmd_has_range,
  input  wire [2:0]  i_cmd_range_kind,
  input  wire [31:0] i_cmd_range_value,
  input  wire        i_cmd_has_res,
  input  wire [1:0]  i_cmd_res_kind,
  input  wire [31:0] i_cmd_res_value,
  input  wire        i_cmd_has_opt_a,
  input  wire        i_cmd_opt_a,
  input  wire        i_cmd_has_opt_b,
  input  wire        i_cmd_opt_b,
  // Integration time below one line cycle
  input  wire        i_nplc_below_one,
  // Measurement engine
  output reg         o_meas_start,
  input  wire        i_meas_done,
  input  wire [31:0] i_meas_data,
  input  wire        i_signal_present,
  // Output buffer toward the controller
  output wire        o_rd_valid,
  input  wire        i_rd_ready,
  output wire [31:0] o_rd_data,
  // Configuration state
  output reg  [3:0]  o_func,
  output reg  [2:0]  o_range,
  output reg         o_autorange,
  output reg  [1:0]  o_res_kind,
  output reg  [31:0] o_res_value,
  output reg  [1:0]  o_digits,
  output reg  [1:0]  o_rtd_sel,
  output reg         o_diode_low_current,
  output reg         o_diode_high_volt,
  output reg         o_ratio_mode,
  output reg         o_ac_bw_20hz,
  output reg         o_autozero,
  output reg         o_dc_filter,
  output reg         o_imp_auto,
  output reg  [15:0] o_sample_count,
  output reg  [15:0] o_trig_count,
  output reg         o_trig_delay_auto,
  output reg         o_trig_src_bus,
  output reg         o_math_on,
  output reg         o_param_error,
  output wire        o_busy,
  output reg  [12:0] o_mem_count
);
  localparam ST_IDLE  = 3'h0;
  localparam ST_TRIG  = 3'h1;
  localparam ST_MEAS  = 3'h2;
  localparam ST_PUSH  = 3'h3;
  localparam ST_FETCH = 3'h4;

  reg         rst_q1;
  reg         rst_q2;
  wire        rstn;
  reg  [2:0]  state;
  reg  [2:0]  next_state;
  reg         to_memory;
  reg  [31:0] meas_left;
  reg  [31:0] reading;
  reg  [12:0] fetch_idx;
  reg  [31:0] mem [0:`MCAF_MEM_DEPTH-1];
  wire        take;
  wire        fifo_in_ready;
  reg         fifo_in_valid;
  reg  [31:0] fifo_in_data;
  wire        flush;
  wire        trg_now;
  wire [3:0]  func_eff;
  wire        cfg_bad;
  wire        is_ac;
  wire [3:0]  fit_idx;

  // Last index of each function's ranges
  function [2:0] top_range;
    input [3:0] fn;
    begin
      case (fn)
        `MCAF_FN_CAP:     top_range = 3'h6;
        `MCAF_FN_CURR_AC: top_range = 3'h5;
        `MCAF_FN_CURR_DC: top_range = 3'h5;
        `MCAF_FN_VOLT_AC: top_range = 3'h4;
        `MCAF_FN_VOLT_DC: top_range = 3'h4;
        `MCAF_FN_RATIO:   top_range = 3'h4;
        `MCAF_FN_RES:     top_range = 3'h6;
        `MCAF_FN_FRES:    top_range = 3'h6;
        default:          top_range = 3'h0;
      endcase
    end
  endfunction

  // Smallest decade range whose full scale covers the amplitude
  function [3:0] fit_range;
    input [31:0] amp;
    integer k;
    reg [31:0] fs;
    reg        found;
    begin
      fs        = `MCAF_RANGE_FS0;
      found     = 1'b0;
      fit_range = 4'hf;
      for (k = 0; k < `MCAF_RANGE_COUNT; k = k + 1) begin
        if (!found && amp <= fs) begin
          fit_range = k[3:0];
          found     = 1'b1;
        end
        fs = fs * 32'd10;
      end
    end
  endfunction

  // Reset released through two flops
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_q1 <= 1'b0;
      rst_q2 <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_q2 <= rst_q1;
    end
  end
  assign rstn = rst_q2;

  assign func_eff = (i_cmd_func == `MCAF_FN_BARE_AC) ? `MCAF_FN_VOLT_AC : i_cmd_func;
  assign is_ac    = (func_eff == `MCAF_FN_VOLT_AC) || (func_eff == `MCAF_FN_CURR_AC);
  assign fit_idx  = fit_range(i_cmd_range_value);

  // A numeric range above a function's top range is an error; fixed-range functions accept any value
  assign cfg_bad =
    (i_cmd_has_res && !i_cmd_has_range) ||
    (func_eff == `MCAF_FN_DIODE && i_cmd_has_opt_b && !i_cmd_has_opt_a) ||
    (i_cmd_has_range && i_cmd_range_kind == `MCAF_RK_NUM &&
     top_range(func_eff) != 3'h0 &&
     fit_range(i_cmd_range_value) > {1'b0, top_range(func_eff)}) ||
    (i_cmd_has_range && i_cmd_range_kind > `MCAF_RK_DEF &&
     func_eff != `MCAF_FN_RTD && func_eff != `MCAF_FN_FRTD) ||
    (i_cmd_func == 4'hf);

  // Bus trigger and device clear are the only commands honoured while busy
  assign trg_now  = i_cmd_valid && i_cmd_op == `MCAF_OP_TRG && o_trig_src_bus &&
                    state == ST_TRIG;
  assign o_cmd_ready = (state == ST_IDLE) || (i_cmd_op == `MCAF_OP_DEVCLR) || trg_now;
  assign take     = i_cmd_valid && o_cmd_ready;
  assign flush    = take && i_cmd_op == `MCAF_OP_DEVCLR;
  assign o_busy   = (state != ST_IDLE);

  // Configuration registers
  always @(posedge i_clock or negedge rstn) begin
    if (!rstn) begin
      o_func              <= `MCAF_FN_VOLT_DC;
      o_range             <= 3'h0;
      o_autorange         <= 1'b1;
      o_res_kind          <= `MCAF_RES_DEF;
      o_res_value         <= 32'h0000_0000;
      o_digits            <= `MCAF_DIG_5H;
      o_rtd_sel           <= `MCAF_RTD_A;
      o_diode_low_current <= 1'b0;
      o_diode_high_volt   <= 1'b0;
      o_ratio_mode        <= 1'b0;
      o_ac_bw_20hz        <= `MCAF_AC_BW_20HZ;
      o_autozero          <= 1'b1;
      o_dc_filter         <= `MCAF_DC_FILTER;
      o_imp_auto          <= `MCAF_IMP_AUTO;
      o_sample_count      <= `MCAF_SAMP_COUNT;
      o_trig_count        <= `MCAF_TRIG_COUNT;
      o_trig_delay_auto   <= `MCAF_DELAY_AUTO;
      o_trig_src_bus      <= 1'b0;
      o_math_on           <= `MCAF_MATH_ON;
      o_param_error       <= 1'b0;
    end else if (take && i_cmd_op == `MCAF_OP_TRIGSRC) begin
      o_trig_src_bus <= i_cmd_opt_a;
    end else if (take && i_cmd_op == `MCAF_OP_CONF) begin
      if (cfg_bad) begin
        o_param_error <= 1'b1;
      end else begin
        // Configuration only; no measurement is started here
        o_param_error     <= 1'b0;
        o_func            <= func_eff;
        o_ratio_mode      <= (func_eff == `MCAF_FN_RATIO);
        o_ac_bw_20hz      <= `MCAF_AC_BW_20HZ;
        o_autozero        <= !i_nplc_below_one;
        o_dc_filter       <= `MCAF_DC_FILTER;
        o_imp_auto        <= `MCAF_IMP_AUTO;
        o_sample_count    <= `MCAF_SAMP_COUNT;
        o_trig_count      <= `MCAF_TRIG_COUNT;
        o_trig_delay_auto <= `MCAF_DELAY_AUTO;
        o_trig_src_bus    <= 1'b0;
        o_math_on         <= `MCAF_MATH_ON;
        o_res_kind        <= i_cmd_has_res ? i_cmd_res_kind : `MCAF_RES_DEF;
        o_res_value       <= i_cmd_has_res ? i_cmd_res_value : 32'h0000_0000;
        if (is_ac) begin
          o_digits <= `MCAF_DIG_6H;
        end else if (!i_cmd_has_res || i_cmd_res_kind == `MCAF_RES_DEF) begin
          o_digits <= `MCAF_DIG_5H;
        end else begin
          o_digits <= `MCAF_DIG_VALUE;
        end
        o_autorange <= 1'b0;
        case (func_eff)
          `MCAF_FN_FREQ, `MCAF_FN_PER: begin
            o_range <= `MCAF_RANGE_SINGLE;
          end
          `MCAF_FN_RTD, `MCAF_FN_FRTD: begin
            o_range <= `MCAF_RANGE_SINGLE;
            if (i_cmd_has_range && i_cmd_range_kind == `MCAF_RK_CURVE_B) begin
              o_rtd_sel <= `MCAF_RTD_B;
            end else if (i_cmd_has_range && i_cmd_range_kind == `MCAF_RK_CUSTOM) begin
              o_rtd_sel <= `MCAF_RTD_CUSTOM;
            end else begin
              o_rtd_sel <= `MCAF_RTD_A;
            end
          end
          `MCAF_FN_DIODE: begin
            o_range             <= `MCAF_RANGE_DIODE;
            o_digits            <= `MCAF_DIG_5H;
            o_diode_low_current <= i_cmd_has_opt_a && i_cmd_opt_a;
            o_diode_high_volt   <= i_cmd_has_opt_b && i_cmd_opt_b;
          end
          `MCAF_FN_CONT: begin
            o_range  <= `MCAF_RANGE_CONT;
            o_digits <= `MCAF_DIG_5H;
          end
          default: begin
            if (!i_cmd_has_range || i_cmd_range_kind == `MCAF_RK_DEF) begin
              o_range     <= 3'h0;
              o_autorange <= 1'b1;
            end else if (i_cmd_range_kind == `MCAF_RK_MIN) begin
              o_range <= 3'h0;
            end else if (i_cmd_range_kind == `MCAF_RK_MAX) begin
              o_range <= top_range(func_eff);
            end else begin
              o_range <= fit_idx[2:0];
            end
          end
        endcase
      end
    end
  end

  // Acquisition sequencer
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (take && i_cmd_op == `MCAF_OP_READ) begin
          next_state = ST_TRIG;
        end else if (take && i_cmd_op == `MCAF_OP_INIT) begin
          next_state = ST_TRIG;
        end else if (take && i_cmd_op == `MCAF_OP_FETCH) begin
          next_state = ST_FETCH;
        end
      end
      ST_TRIG: begin
        if (!o_trig_src_bus || trg_now) begin
          next_state = ST_MEAS;
        end
      end
      ST_MEAS: begin
        if (i_meas_done) begin
          next_state = ST_PUSH;
        end
      end
      ST_PUSH: begin
        if (to_memory || fifo_in_ready) begin
          next_state = (meas_left == 32'h0000_0001) ? ST_IDLE : ST_TRIG;
        end
      end
      ST_FETCH: begin
        if (fetch_idx >= o_mem_count) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    if (flush) begin
      next_state = ST_IDLE;
    end
  end

  always @(posedge i_clock or negedge rstn) begin
    if (!rstn) begin
      state        <= ST_IDLE;
      to_memory    <= 1'b0;
      meas_left    <= 32'h0000_0000;
      reading      <= 32'h0000_0000;
      fetch_idx    <= 13'h0000;
      o_mem_count  <= 13'h0000;
      o_meas_start <= 1'b0;
    end else begin
      state        <= next_state;
      o_meas_start <= (state == ST_TRIG) && (next_state == ST_MEAS);
      if (state == ST_IDLE && take &&
          (i_cmd_op == `MCAF_OP_READ || i_cmd_op == `MCAF_OP_INIT)) begin
        to_memory <= (i_cmd_op == `MCAF_OP_INIT);
        meas_left <= o_sample_count * o_trig_count;
        if (i_cmd_op == `MCAF_OP_INIT) begin
          o_mem_count <= 13'h0000;
        end
      end
      if (state == ST_IDLE && take && i_cmd_op == `MCAF_OP_FETCH) begin
        fetch_idx <= 13'h0000;
      end
      if (state == ST_MEAS && i_meas_done) begin
        if ((o_func == `MCAF_FN_FREQ || o_func == `MCAF_FN_PER) && !i_signal_present) begin
          reading <= 32'h0000_0000;
        end else begin
          reading <= i_meas_data;
        end
      end
      if (state == ST_PUSH && (to_memory || fifo_in_ready)) begin
        meas_left <= meas_left - 32'h0000_0001;
        if (to_memory && o_mem_count < `MCAF_MEM_DEPTH) begin
          o_mem_count <= o_mem_count + 13'h0001;
        end
      end
      if (state == ST_FETCH && fifo_in_ready && fetch_idx < o_mem_count) begin
        fetch_idx <= fetch_idx + 13'h0001;
      end
    end
  end

  // Reading memory; full memory drops further readings
  always @(posedge i_clock) begin
    if (state == ST_PUSH && to_memory && o_mem_count < `MCAF_MEM_DEPTH) begin
      mem[o_mem_count] <= reading;
    end
  end

  // Buffer writes stall the sequencer when the buffer is full
  always @* begin
    fifo_in_valid = 1'b0;
    fifo_in_data  = reading;
    if (state == ST_PUSH && !to_memory) begin
      fifo_in_valid = 1'b1;
    end else if (state == ST_FETCH && fetch_idx < o_mem_count) begin
      fifo_in_valid = 1'b1;
      fifo_in_data  = mem[fetch_idx];
    end
  end

  mcaf_fifo #(
    .WIDTH (`MCAF_DATA_W),
    .DEPTH (`MCAF_FIFO_DEPTH),
    .AW    (`MCAF_FIFO_AW)
  ) u_out_buffer (
    .i_clock     (i_clock),
    .i_rstn      (rstn),
    .i_flush     (flush),
    .i_in_valid  (fifo_in_valid),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (fifo_in_data),
    .o_out_valid (o_rd_valid),
    .i_out_ready (i_rd_ready),
    .o_out_data  (o_rd_data)
  );
endmodule // mcaf_top

// *** inc/mcaf_defines.vh ***
// Constants for the meter configure and acquire flow
`ifndef MCAF_DEFINES_VH
`define MCAF_DEFINES_VH

// Command operation codes
`define MCAF_OP_CONF      3'h0
`define MCAF_OP_READ      3'h1
`define MCAF_OP_INIT      3'h2
`define MCAF_OP_FETCH     3'h3
`define MCAF_OP_TRG       3'h4
`define MCAF_OP_DEVCLR    3'h5
`define MCAF_OP_TRIGSRC   3'h6

// Function codes
`define MCAF_FN_CAP       4'h0
`define MCAF_FN_CURR_AC   4'h1
`define MCAF_FN_CURR_DC   4'h2
`define MCAF_FN_VOLT_AC   4'h3
`define MCAF_FN_VOLT_DC   4'h4
`define MCAF_FN_RATIO     4'h5
`define MCAF_FN_RES       4'h6
`define MCAF_FN_FRES      4'h7
`define MCAF_FN_FREQ      4'h8
`define MCAF_FN_PER       4'h9
`define MCAF_FN_RTD       4'ha
`define MCAF_FN_FRTD      4'hb
`define MCAF_FN_DIODE     4'hc
`define MCAF_FN_CONT      4'hd
`define MCAF_FN_BARE_AC   4'he

// Range argument kinds
`define MCAF_RK_NUM       3'h0
`define MCAF_RK_MIN       3'h1
`define MCAF_RK_MAX       3'h2
`define MCAF_RK_DEF       3'h3
`define MCAF_RK_CURVE_A   3'h4
`define MCAF_RK_CURVE_B   3'h5
`define MCAF_RK_CUSTOM    3'h6

// Resolution argument kinds
`define MCAF_RES_NUM      2'h0
`define MCAF_RES_MIN      2'h1
`define MCAF_RES_MAX      2'h2
`define MCAF_RES_DEF      2'h3

// Digit settings: by value, five and a half, six and a half
`define MCAF_DIG_VALUE    2'h0
`define MCAF_DIG_5H       2'h1
`define MCAF_DIG_6H       2'h2

// Sensor selections
`define MCAF_RTD_A        2'h0
`define MCAF_RTD_B        2'h1
`define MCAF_RTD_CUSTOM   2'h2

// Fixed ranges: diode 10 V, continuity 1 kohm
`define MCAF_RANGE_DIODE  3'h2
`define MCAF_RANGE_CONT   3'h3
`define MCAF_RANGE_SINGLE 3'h0
`define MCAF_RANGE_COUNT  7
`define MCAF_RANGE_FS0    32'h0000_0064

// Presets
`define MCAF_AC_BW_20HZ   1'b1
`define MCAF_DC_FILTER    1'b1
`define MCAF_IMP_AUTO     1'b0
`define MCAF_SAMP_COUNT   16'h0001
`define MCAF_TRIG_COUNT   16'h0001
`define MCAF_DELAY_AUTO   1'b1
`define MCAF_MATH_ON      1'b0

// Reading memory and output buffer
`define MCAF_MEM_DEPTH    5000
`define MCAF_MEM_AW       13
`define MCAF_DATA_W       32
`define MCAF_FIFO_DEPTH   16
`define MCAF_FIFO_AW      4

`endif

// *** logic/mcaf_fifo.v ***
// Output buffer FIFO with flush
`timescale 1ns/1ps
module mcaf_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             i_clock,
  input  wire             i_rstn,
  input  wire             i_flush,
  input  wire             i_in_valid,
  output wire             o_in_ready,
  input  wire [WIDTH-1:0] i_in_data,
  output wire             o_out_valid,
  input  wire             i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            push;
  wire            pop;

  assign o_in_ready  = (count != DEPTH[AW:0]);
  assign o_out_valid = (count != {(AW+1){1'b0}});
  assign o_out_data  = mem[rd_ptr];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  always @(posedge i_clock) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else if (i_flush) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // mcaf_fifo

// *** bench/mcaf_top_properties.sv ***
// Port checker for the configure and acquire flow
`timescale 1ns/1ps
`include "mcaf_defines.vh"
module mcaf_top_properties (
  input wire        i_clock,
  input wire        i_rstn,
  input wire        i_cmd_valid,
  input wire        o_cmd_ready,
  input wire [2:0]  i_cmd_op,
  input wire [3:0]  i_cmd_func,
  input wire        i_cmd_has_range,
  input wire        i_cmd_has_res,
  input wire        i_nplc_below_one,
  input wire        o_meas_start,
  input wire        o_rd_valid,
  input wire [3:0]  o_func,
  input wire [1:0]  o_digits,
  input wire        o_autozero,
  input wire        o_dc_filter,
  input wire        o_imp_auto,
  input wire [15:0] o_sample_count,
  input wire [15:0] o_trig_count,
  input wire        o_trig_delay_auto,
  input wire        o_trig_src_bus,
  input wire        o_math_on,
  input wire        o_ac_bw_20hz,
  input wire        o_param_error,
  input wire        o_busy
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  wire take = i_cmd_valid && o_cmd_ready;
  wire conf = take && i_cmd_op == `MCAF_OP_CONF;
  wire is_ac = i_cmd_func == `MCAF_FN_VOLT_AC || i_cmd_func == `MCAF_FN_CURR_AC
    || i_cmd_func == `MCAF_FN_BARE_AC;
  sequence s_acq;
    take && (i_cmd_op == `MCAF_OP_READ || i_cmd_op == `MCAF_OP_INIT) && !o_trig_src_bus;
  endsequence
  sequence s_start_late;
    !o_meas_start ##1 o_meas_start;
  endsequence
  AST_CONF_NO_MEAS: assert property (conf |=> !o_meas_start [*2])
    else $error("measurement started by configure");
  AST_ACQ_START: assert property (s_acq |=> s_start_late)
    else $error("start pulse not two cycles after acquire");
  AST_BUS_TRG: assert property (take && i_cmd_op == `MCAF_OP_TRG && o_busy |=> o_meas_start)
    else $error("bus trigger did not start measurement");
  AST_BUSY_REFUSE: assert property (o_busy && i_cmd_op != `MCAF_OP_DEVCLR
    && i_cmd_op != `MCAF_OP_TRG |-> !o_cmd_ready)
    else $error("command taken while busy");
  AST_PRESETS: assert property (conf |=> o_param_error || (o_dc_filter && !o_imp_auto
    && o_sample_count == 16'h0001 && o_trig_count == 16'h0001 && o_trig_delay_auto
    && !o_math_on && o_ac_bw_20hz && !o_trig_src_bus))
    else $error("preset conditions wrong after configure");
  AST_AUTOZERO: assert property (conf |=> o_param_error
    || o_autozero == !$past(i_nplc_below_one))
    else $error("autozero does not follow integration time");
  AST_AC_DIGITS: assert property (conf && is_ac |=> o_param_error
    || o_digits == `MCAF_DIG_6H)
    else $error("ac function not at six and a half digits");
  AST_BARE_AC: assert property (conf && i_cmd_func == `MCAF_FN_BARE_AC |=> o_param_error
    || o_func == `MCAF_FN_VOLT_AC)
    else $error("bare ac keyword not volts ac");
  AST_RES_NEEDS_RANGE: assert property (conf && i_cmd_has_res && !i_cmd_has_range
    |=> o_param_error && $stable(o_func))
    else $error("resolution without range accepted");
  AST_CLEAR_FLUSH: assert property (take && i_cmd_op == `MCAF_OP_DEVCLR
    |=> !o_busy && !o_rd_valid)
    else $error("device clear left data or activity");
endmodule // mcaf_top_properties

bind mcaf_top mcaf_top_properties mcaf_top_properties_i (.*);

// *** bench/mcaf_meas_model.sv ***
// Measurement engine stand-in answering start pulses after a set delay
`timescale 1ns/1ps
module mcaf_meas_model (
  input  wire        i_clock,
  input  wire        i_start,
  input  wire [7:0]  i_delay,
  output reg         o_done,
  output reg  [31:0] o_data
);
  reg [7:0]  cnt = 8'h00;
  reg        run = 1'b0;
  reg [31:0] n = 32'h0;
  initial begin
    o_done = 1'b0;
    o_data = 32'h0;
  end
  always @(posedge i_clock) begin
    o_done <= 1'b0;
    // Data is only valid with done, so scramble it otherwise
    o_data <= ~o_data;
    if (i_start) begin
      run <= 1'b1;
      cnt <= i_delay;
    end else if (run && cnt == 8'h00) begin
      run <= 1'b0;
      o_done <= 1'b1;
      o_data <= 32'h0000_1000 + n;
      n <= n + 32'h1;
    end else if (run) begin
      cnt <= cnt - 8'h01;
    end
  end
endmodule // mcaf_meas_model

// *** bench/mcaf_top_bench.sv ***
// Self-checking bench for the configure and acquire flow
`timescale 1ns/1ps
`include "mcaf_defines.vh"
module mcaf_top_bench;
  reg         i_clock = 1'b0;
  reg         i_rstn = 1'b0;
  reg         i_cmd_valid = 1'b0;
  reg  [2:0]  i_cmd_op = 3'h0;
  reg  [3:0]  i_cmd_func = 4'h4;
  reg         i_cmd_has_range = 1'b0;
  reg  [2:0]  i_cmd_range_kind = 3'h0;
  reg  [31:0] i_cmd_range_value = 32'h0;
  reg         i_cmd_has_res = 1'b0;
  reg  [1:0]  i_cmd_res_kind = 2'h3;
  reg  [31:0] i_cmd_res_value = 32'h0;
  reg         i_cmd_has_opt_a = 1'b0;
  reg         i_cmd_opt_a = 1'b0;
  reg         i_cmd_has_opt_b = 1'b0;
  reg         i_cmd_opt_b = 1'b0;
  reg         i_nplc_below_one = 1'b1;
  reg         i_signal_present = 1'b0;
  reg         i_rd_ready = 1'b0;
  reg  [7:0]  delay = 8'h02;
  wire        o_cmd_ready, o_meas_start, i_meas_done, o_rd_valid, o_busy, o_autorange;
  wire        o_diode_low_current, o_diode_high_volt, o_ratio_mode, o_autozero, o_param_error;
  wire [31:0] i_meas_data, o_rd_data;
  wire [3:0]  o_func;
  wire [2:0]  o_range;
  wire [1:0]  o_digits, o_rtd_sel;
  wire [12:0] o_mem_count;
  integer     failures = 0, compares = 0, cyc = 0, i, k;

  mcaf_top mcaf_top_i (.*, .o_res_kind(), .o_res_value(), .o_ac_bw_20hz(), .o_dc_filter(),
    .o_imp_auto(), .o_sample_count(), .o_trig_count(), .o_trig_delay_auto(),
    .o_trig_src_bus(), .o_math_on());
  mcaf_meas_model mcaf_meas_model_i (.i_clock(i_clock), .i_start(o_meas_start),
    .i_delay(delay), .o_done(i_meas_done), .o_data(i_meas_data));

  always #5 i_clock = ~i_clock;

  task end_of_test;
    begin
      if (failures == 0 && compares > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask

  // Whole run needs a few hundred cycles
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures = failures + 1;
      end_of_test;
    end
  end

  task chk(input [31:0] g, input [31:0] e);
    begin
      compares = compares + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("[ERR] t=%0t got %h exp %h", $time, g, e);
      end
    end
  endtask

  // Option pairs are {given, value}
  task cmd(input [2:0] op, input [3:0] fn, input hr, input [2:0] rk, input [31:0] rv,
    input hs, input [1:0] oa, input [1:0] ob);
    begin
      @(posedge i_clock);
      i_cmd_valid <= 1'b1;
      i_cmd_op <= op;
      i_cmd_func <= fn;
      i_cmd_has_range <= hr;
      i_cmd_range_kind <= rk;
      i_cmd_range_value <= rv;
      i_cmd_has_res <= hs;
      {i_cmd_has_opt_a, i_cmd_opt_a} <= oa;
      {i_cmd_has_opt_b, i_cmd_opt_b} <= ob;
      k = 0;
      @(posedge i_clock);
      while (!o_cmd_ready && k < 300) begin
        k = k + 1;
        @(posedge i_clock);
      end
      chk(k < 300, 1);
      i_cmd_valid <= 1'b0;
    end
  endtask

  task conf(input [3:0] fn, input hr, input [2:0] rk, input [31:0] rv, input hs,
    input [1:0] oa, input [1:0] ob);
    begin
      cmd(`MCAF_OP_CONF, fn, hr, rk, rv, hs, oa, ob);
      @(posedge i_clock);
    end
  endtask

  task act(input [2:0] op);
    cmd(op, `MCAF_FN_VOLT_DC, 1'b0, 3'h0, 32'h0, 1'b0, 2'h0, 2'h0);
  endtask

  task wait_idle;
    begin
      k = 0;
      @(posedge i_clock);
      while (o_busy && k < 300) begin
        k = k + 1;
        @(posedge i_clock);
      end
      chk(k < 300, 1);
    end
  endtask

  task pop(input [31:0] e);
    begin
      @(posedge i_clock);
      i_rd_ready <= 1'b1;
      k = 0;
      @(posedge i_clock);
      while (!o_rd_valid && k < 300) begin
        k = k + 1;
        @(posedge i_clock);
      end
      chk(o_rd_data, e);
      i_rd_ready <= 1'b0;
    end
  endtask

  initial begin
    repeat (5) @(posedge i_clock);
    i_rstn <= 1'b1;
    repeat (3) @(posedge i_clock);
    chk({o_func, o_digits, o_autorange}, {`MCAF_FN_VOLT_DC, `MCAF_DIG_5H, 1'b1});
    conf(`MCAF_FN_VOLT_DC, 1, `MCAF_RK_NUM, 32'd500, 0, 0, 0);
    chk({o_range, o_autorange, o_autozero, o_param_error}, {3'h1, 3'h0});
    conf(`MCAF_FN_VOLT_DC, 1, `MCAF_RK_MIN, 0, 0, 0, 0);
    chk(o_range, 0);
    conf(`MCAF_FN_VOLT_DC, 1, `MCAF_RK_MAX, 0, 0, 0, 0);
    chk(o_range, 4);
    conf(`MCAF_FN_VOLT_DC, 1, `MCAF_RK_DEF, 0, 1, 0, 0);
    chk({o_autorange, o_digits}, {1'b1, `MCAF_DIG_5H});
    conf(`MCAF_FN_BARE_AC, 0, 0, 0, 0, 0, 0);
    chk({o_func, o_digits}, {`MCAF_FN_VOLT_AC, `MCAF_DIG_6H});
    conf(`MCAF_FN_CURR_AC, 1, `MCAF_RK_DEF, 0, 1, 0, 0);
    chk(o_digits, `MCAF_DIG_6H);
    conf(`MCAF_FN_CURR_DC, 0, 0, 0, 1, 0, 0);
    chk({o_param_error, o_func}, {1'b1, `MCAF_FN_CURR_AC});
    conf(`MCAF_FN_DIODE, 0, 0, 0, 0, 2'b00, 2'b11);
    chk(o_param_error, 1);
    conf(`MCAF_FN_DIODE, 0, 0, 0, 0, 2'b11, 2'b11);
    chk({o_param_error, o_range, o_diode_low_current, o_diode_high_volt, o_digits},
      {1'b0, `MCAF_RANGE_DIODE, 2'b11, `MCAF_DIG_5H});
    conf(`MCAF_FN_DIODE, 0, 0, 0, 0, 2'b10, 2'b10);
    chk({o_diode_low_current, o_diode_high_volt}, 0);
    conf(`MCAF_FN_CONT, 1, `MCAF_RK_NUM, 32'h00ff_ffff, 1, 0, 0);
    chk({o_param_error, o_range, o_digits}, {1'b0, `MCAF_RANGE_CONT, `MCAF_DIG_5H});
    for (i = 0; i < 3; i = i + 1) begin
      conf(`MCAF_FN_RTD, 1, `MCAF_RK_CURVE_A + i[2:0], 0, 0, 0, 0);
      chk(o_rtd_sel, i);
    end
    conf(`MCAF_FN_RATIO, 1, `MCAF_RK_NUM, 32'd50, 0, 0, 0);
    chk({o_ratio_mode, o_range}, {1'b1, 3'h0});
    conf(`MCAF_FN_PER, 1, `MCAF_RK_NUM, 32'd1, 1, 0, 0);
    chk({o_param_error, o_range}, {1'b0, `MCAF_RANGE_SINGLE});
    act(`MCAF_OP_READ);
    pop(0);
    conf(`MCAF_FN_FREQ, 1, `MCAF_RK_NUM, 32'd1000, 1, 0, 0);
    chk(o_range, `MCAF_RANGE_SINGLE);
    act(`MCAF_OP_READ);
    pop(0);
    i_signal_present <= 1'b1;
    conf(`MCAF_FN_VOLT_DC, 0, 0, 0, 0, 0, 0);
    act(`MCAF_OP_READ);
    wait_idle;
    chk(o_mem_count, 0);
    pop(32'h1002);
    for (i = 0; i < 17; i = i + 1) begin
      act(`MCAF_OP_READ);
      if (i < 16)
        wait_idle;
    end
    repeat (30) @(posedge i_clock);
    chk(o_busy, 1);
    for (i = 0; i < 17; i = i + 1)
      pop(32'h1003 + i);
    act(`MCAF_OP_READ);
    wait_idle;
    act(`MCAF_OP_DEVCLR);
    @(posedge i_clock);
    chk({o_rd_valid, o_busy}, 0);
    delay <= 8'd20;
    act(`MCAF_OP_INIT);
    repeat (4) @(posedge i_clock);
    chk({o_busy, o_cmd_ready}, 2'b10);
    wait_idle;
    chk({o_mem_count, o_rd_valid}, {13'h1, 1'b0});
    cmd(`MCAF_OP_TRIGSRC, 0, 0, 0, 0, 0, 2'b11, 2'b00);
    act(`MCAF_OP_INIT);
    repeat (30) @(posedge i_clock);
    chk({o_busy, o_mem_count}, {1'b1, 13'h0});
    act(`MCAF_OP_TRG);
    wait_idle;
    chk(o_mem_count, 1);
    // Memory survives a fetch, so a second one gives the same word
    for (i = 0; i < 2; i = i + 1) begin
      act(`MCAF_OP_FETCH);
      pop(32'h1016);
      wait_idle;
    end
    chk(o_mem_count, 1);
    end_of_test;
  end
endmodule // mcaf_top_bench
